// ### verilog/eeprom_link_pkg.sv
// shared constants and state types for the two-wire eeprom link
`default_nettype none
package eeprom_link_pkg;
    // clocking and timing
    localparam int CLK_HZ = 100_000_000;
    localparam int WRITE_CYCLE_TIME_MS = 10;
    // longest time: rounds down
    localparam int WRITE_CYCLE_CNT = CLK_HZ / 1000 * WRITE_CYCLE_TIME_MS;
    localparam int SCL_HZ = 100_000;
    localparam int SCL_QUARTER_CNT = CLK_HZ / (4 * SCL_HZ);
    localparam int TMR_W = 24;
    localparam int QCNT_W = 16;
    // array organisation
    localparam int MEM_DEPTH = 128;
    localparam int PAGE_BYTES = 8;
    localparam logic [7:0] MEM_RESET_VAL = 8'hff;
    // serial framing
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam logic [3:0] DEV_TYPE_CODE = 4'ha;
    localparam logic [7:0] DEV_ADDR_WR = 8'ha0;
    localparam logic [7:0] DEV_ADDR_RD = 8'ha1;

    typedef enum logic [2:0] {
        D_IDLE = 3'b000,
        D_DEV = 3'b001,
        D_WADDR = 3'b010,
        D_WDATA = 3'b011,
        D_RDATA = 3'b100,
        D_BUSY = 3'b101
    } dev_state_t;

    typedef enum logic [3:0] {
        M_IDLE = 4'b0000,
        M_START = 4'b0001,
        M_DEVW = 4'b0010,
        M_ADDR = 4'b0011,
        M_WDAT = 4'b0100,
        M_RSTART = 4'b0101,
        M_DEVR = 4'b0110,
        M_RDAT = 4'b0111,
        M_STOP = 4'b1000
    } host_state_t;
endpackage
`default_nettype wire

// ### verilog/eeprom_link_if.sv
// two-wire link between bus master and eeprom, with wired-and data line
`timescale 1ns/10ps
`default_nettype none
interface eeprom_link_if;
    logic scl;
    logic aux_clock_pin;
    logic host_sda_o;
    logic host_sda_oe_n;
    logic dev_sda_o;
    logic dev_sda_oe_n;
    logic sda;

    // open drain with pull-up: a released end reads as one
    assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

    modport host (
        output scl,
        output aux_clock_pin,
        output host_sda_o,
        output host_sda_oe_n,
        input sda
    );

    modport device (
        input scl,
        input aux_clock_pin,
        input sda,
        output dev_sda_o,
        output dev_sda_oe_n
    );
endinterface
`default_nettype wire

// ### verilog/eeprom_dev.sv
// eeprom end: two-wire slave with page buffer, self-timed write and address counter
//
// Overview of operation
// [R01] word address byte follows write device address, acked
// [R02] byte write data acked, master then stops
// [R03] stop after write starts timed programming
// [R04] busy device ignores bus, never acks
// [R05] aux pin high needed; started cycle completes
// [R06] page write collects up to eight bytes
// [R07] each further page byte acked, stop ends
// [R08] low three address bits wrap within page
// [R09] address ack only after programming finished
// [R10] aux pin low makes array read-only
// [R11] low supply inhibits all array writes
// [R12] direction bit one starts a read
// [R13] counter holds last accessed address plus one
// [R14] read counter wraps from last to first
// [R15] current read sends byte at counter
// [R16] random read: dummy write, restart, read
// [R17] master ack advances address, sends next
// [R18] ack drives data low in ninth clock
// [R19] type code 1010 must match, else standby
// [R20] word address uses low seven bits
`timescale 1ns/10ps
`default_nettype none
module eeprom_dev
    import eeprom_link_pkg::*;
#(
    parameter int WR_CYCLES = WRITE_CYCLE_CNT
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // link pins
    eeprom_link_if.device link,
    // supply monitor and status
    input wire logic supply_low,
    output logic write_busy
);
    // synchronisers: bit 0 scl, 1 sda, 2 aux pin, 3 supply low
    logic [3:0] sync1_ff;
    logic [3:0] sync2_ff;
    logic [1:0] prev_ff;
    logic scl_s;
    logic sda_s;
    logic aux_s;
    logic low_s;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    // protocol state
    dev_state_t st_ff;
    dev_state_t nxt_st;
    logic [3:0] cnt_ff;
    logic [3:0] nxt_cnt;
    logic [7:0] sh_ff;
    logic [7:0] nxt_sh;
    logic [7:0] tx_ff;
    logic [7:0] nxt_tx;
    logic [6:0] addr_ff;
    logic [6:0] nxt_addr;
    logic [7:0][7:0] pbuf_ff;
    logic [7:0][7:0] nxt_pbuf;
    logic [7:0] pval_ff;
    logic [7:0] nxt_pval;
    logic wp_bad_ff;
    logic nxt_wp_bad;
    logic oen_ff;
    logic nxt_oen;
    logic [TMR_W-1:0] tmr_ff;
    logic [TMR_W-1:0] nxt_tmr;

    // array port
    logic [7:0] mem [MEM_DEPTH];
    logic mem_we;
    logic [6:0] mem_wa;
    logic [7:0] mem_wd;
    logic [2:0] prog_idx;

    // pins are asynchronous to ref_clk: two flops before any use
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            // scl and sda start at their idle high level: no false edge after reset
            sync1_ff <= 4'h3;
            sync2_ff <= 4'h3;
            prev_ff <= 2'h3;
        end else begin
            sync1_ff <= {supply_low, link.aux_clock_pin, link.sda, link.scl};
            sync2_ff <= sync1_ff;
            prev_ff <= sync2_ff[1:0];
        end
    end

    // edges and bus conditions from the synchronised pins
    assign scl_s = sync2_ff[0];
    assign sda_s = sync2_ff[1];
    assign aux_s = sync2_ff[2];
    assign low_s = sync2_ff[3];
    assign scl_rise = scl_s & ~prev_ff[0];
    assign scl_fall = ~scl_s & prev_ff[0];
    assign start_det = scl_s & prev_ff[0] & prev_ff[1] & ~sda_s;
    assign stop_det = scl_s & prev_ff[0] & ~prev_ff[1] & sda_s;
    assign prog_idx = tmr_ff[2:0];

    // next-state logic for the protocol engine
    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_sh = sh_ff;
        nxt_tx = tx_ff;
        nxt_addr = addr_ff;
        nxt_pbuf = pbuf_ff;
        nxt_pval = pval_ff;
        nxt_wp_bad = wp_bad_ff;
        nxt_oen = oen_ff;
        nxt_tmr = tmr_ff;
        mem_we = 1'b0;
        mem_wa = {addr_ff[6:3], prog_idx};
        mem_wd = pbuf_ff[prog_idx];
        if (st_ff == D_BUSY) begin
            // bus fully ignored here, so polls see no ack
            nxt_oen = 1'b1; // R04 R09
            nxt_tmr = tmr_ff + 1'b1;
            // aux pin is not looked at: the cycle always completes
            if (tmr_ff < TMR_W'(PAGE_BYTES) && pval_ff[prog_idx] && !low_s) begin
                mem_we = 1'b1; // R05 R11
            end
            if (tmr_ff == TMR_W'(WR_CYCLES - 1)) begin
                nxt_st = D_IDLE; // R03
                nxt_pval = 8'h00;
            end
        end else if (start_det) begin
            nxt_st = D_DEV;
            nxt_cnt = 4'h0;
            nxt_oen = 1'b1;
            nxt_wp_bad = 1'b0;
            nxt_pval = 8'h00;
        end else if (stop_det) begin
            nxt_oen = 1'b1;
            nxt_st = D_IDLE;
            // protected or low-supply sequences are dropped, not programmed
            if (st_ff == D_WDATA && pval_ff != 8'h00 && !wp_bad_ff && aux_s && !low_s) begin
                nxt_st = D_BUSY; // R03 R10 R11
                nxt_tmr = '0;
            end
        end else if (st_ff != D_IDLE) begin
            if (scl_rise) begin
                if ((st_ff == D_WADDR || st_ff == D_WDATA) && !aux_s) begin
                    nxt_wp_bad = 1'b1; // R05 R10
                end
                if (cnt_ff != ACK_BIT) begin
                    nxt_sh = {sh_ff[6:0], sda_s};
                    nxt_tx = {tx_ff[6:0], 1'b1};
                    nxt_cnt = cnt_ff + 4'h1;
                end else begin
                    // ninth clock: act on the byte just completed
                    nxt_cnt = 4'h0;
                    case (st_ff)
                        D_DEV: begin
                            if (sh_ff[0]) begin
                                nxt_st = D_RDATA; // R12
                                nxt_tx = mem[addr_ff]; // R15
                                nxt_addr = addr_ff + 7'h01; // R13 R14
                            end else begin
                                nxt_st = D_WADDR; // R01
                            end
                        end
                        D_WADDR: begin
                            nxt_addr = sh_ff[6:0]; // R20
                            nxt_st = D_WDATA;
                            nxt_pval = 8'h00;
                        end
                        D_WDATA: begin
                            nxt_pbuf[addr_ff[2:0]] = sh_ff; // R06
                            nxt_pval[addr_ff[2:0]] = 1'b1;
                            nxt_addr = {addr_ff[6:3], addr_ff[2:0] + 3'h1}; // R08
                        end
                        D_RDATA: begin
                            if (!sda_s) begin
                                nxt_tx = mem[addr_ff]; // R17
                                nxt_addr = addr_ff + 7'h01; // R14
                            end else begin
                                nxt_st = D_IDLE; // R15
                            end
                        end
                        default: nxt_st = D_IDLE;
                    endcase
                end
            end
            if (scl_fall) begin
                if (st_ff == D_RDATA) begin
                    // open drain: release for one, drive low for zero
                    nxt_oen = (cnt_ff == ACK_BIT) ? 1'b1 : tx_ff[7];
                end else if (cnt_ff != ACK_BIT) begin
                    nxt_oen = 1'b1;
                end else if (st_ff == D_DEV && sh_ff[7:4] != DEV_TYPE_CODE) begin
                    nxt_st = D_IDLE; // R19
                    nxt_oen = 1'b1;
                end else begin
                    nxt_oen = 1'b0; // R18 R01 R02 R07
                end
            end
        end
    end

    // protocol registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_ff <= D_IDLE;
            cnt_ff <= 4'h0;
            sh_ff <= 8'h00;
            tx_ff <= 8'hff;
            addr_ff <= 7'h00;
            pbuf_ff <= '0;
            pval_ff <= 8'h00;
            wp_bad_ff <= 1'b0;
            oen_ff <= 1'b1;
            tmr_ff <= '0;
        end else begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            sh_ff <= nxt_sh;
            tx_ff <= nxt_tx;
            addr_ff <= nxt_addr;
            pbuf_ff <= nxt_pbuf;
            pval_ff <= nxt_pval;
            wp_bad_ff <= nxt_wp_bad;
            oen_ff <= nxt_oen;
            tmr_ff <= nxt_tmr;
        end
    end

    // array: erased at reset so reads are never unknown
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < MEM_DEPTH; i++) begin
                mem[i] <= MEM_RESET_VAL;
            end
        end else if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    // pin and status outputs
    assign link.dev_sda_o = 1'b0;
    assign link.dev_sda_oe_n = oen_ff;
    assign write_busy = (st_ff == D_BUSY);
endmodule
`default_nettype wire

// ### verilog/eeprom_host.sv
// bus master end: generates scl, runs write, random and sequential reads
`timescale 1ns/10ps
`default_nettype none
module eeprom_host
    import eeprom_link_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // link pins
    eeprom_link_if.host link,
    // write enable level for the aux pin
    input wire logic aux_level,
    // command
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [6:0] cmd_addr,
    input wire logic [3:0] cmd_count,
    output logic cmd_ready,
    // write data
    input wire logic [7:0] wr_data,
    output logic wr_take,
    // read data and completion
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic done,
    output logic nack
);
    logic [1:0] sync_ff;
    logic sda_s;
    logic tick;
    host_state_t st_ff;
    host_state_t nxt_st;
    logic [QCNT_W-1:0] q_ff;
    logic [QCNT_W-1:0] nxt_q;
    logic [1:0] ph_ff;
    logic [1:0] nxt_ph;
    logic [3:0] bit_ff;
    logic [3:0] nxt_bit;
    logic [7:0] txb_ff;
    logic [7:0] nxt_txb;
    logic [7:0] rxb_ff;
    logic [7:0] nxt_rxb;
    logic [3:0] cnt_ff;
    logic [3:0] nxt_cnt;
    logic wr_ff;
    logic nxt_wr;
    logic [6:0] addr_ff;
    logic [6:0] nxt_addr;
    logic samp_ff;
    logic nxt_samp;
    logic drv_ff;
    logic nxt_drv;
    logic scl_ff;
    logic nxt_scl;
    logic aux_ff;
    logic nack_ff;
    logic nxt_nack;
    logic [7:0] rd_ff;
    logic [7:0] nxt_rd;
    logic rdv_ff;
    logic nxt_rdv;
    logic take_ff;
    logic nxt_take;
    logic done_ff;
    logic nxt_done;

    // scl level for a state and phase; stop keeps scl high after its rise
    function automatic logic scl_of(host_state_t s, logic [1:0] p);
        if (s == M_IDLE) return 1'b1;
        if (s == M_STOP) return p != 2'h0;
        return p == 2'h1 || p == 2'h2;
    endfunction

    // sda pull-down for a state, phase and bit position
    function automatic logic drv_of(host_state_t s, logic [1:0] p, logic [3:0] b,
                                    logic [7:0] t, logic [3:0] c);
        case (s)
            M_START, M_RSTART: return p[1];
            M_STOP: return ~p[1];
            M_DEVW, M_ADDR, M_WDAT, M_DEVR: return (b != ACK_BIT) && !t[7];
            M_RDAT: return (b == ACK_BIT) && (c != 4'h1); // R15 R17
            default: return 1'b0;
        endcase
    endfunction

    // data line comes back through the wired-and: synchronise it
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync_ff <= 2'h3;
            aux_ff <= 1'b0;
        end else begin
            sync_ff <= {sync_ff[0], link.sda};
            aux_ff <= aux_level; // R05
        end
    end
    assign sda_s = sync_ff[1];
    assign tick = (q_ff == QCNT_W'(SCL_QUARTER_CNT - 1));

    // sequencer: one scl period is four quarter phases
    always_comb begin
        nxt_st = st_ff;
        nxt_q = q_ff;
        nxt_ph = ph_ff;
        nxt_bit = bit_ff;
        nxt_txb = txb_ff;
        nxt_rxb = rxb_ff;
        nxt_cnt = cnt_ff;
        nxt_wr = wr_ff;
        nxt_addr = addr_ff;
        nxt_samp = samp_ff;
        nxt_nack = nack_ff;
        nxt_rd = rd_ff;
        nxt_rdv = 1'b0;
        nxt_take = 1'b0;
        nxt_done = 1'b0;
        if (st_ff == M_IDLE) begin
            if (cmd_valid) begin
                nxt_st = M_START;
                nxt_wr = cmd_write;
                nxt_addr = cmd_addr;
                nxt_cnt = cmd_count;
                nxt_ph = 2'h0;
                nxt_q = '0;
                nxt_nack = 1'b0;
            end
        end else if (!tick) begin
            nxt_q = q_ff + 1'b1;
        end else begin
            nxt_q = '0;
            nxt_ph = ph_ff + 2'h1;
            // sample in the middle of scl high
            if (ph_ff == 2'h1) begin
                nxt_samp = sda_s;
                if (st_ff == M_RDAT && bit_ff != ACK_BIT) begin
                    nxt_rxb = {rxb_ff[6:0], sda_s};
                end
            end
            if (ph_ff == 2'h3) begin
                nxt_bit = 4'h0;
                if (st_ff == M_START || st_ff == M_RSTART) begin
                    nxt_st = (st_ff == M_START) ? M_DEVW : M_DEVR;
                    nxt_txb = (st_ff == M_START) ? DEV_ADDR_WR : DEV_ADDR_RD;
                end else if (st_ff == M_STOP) begin
                    nxt_st = M_IDLE;
                    nxt_done = 1'b1;
                end else if (bit_ff != ACK_BIT) begin
                    nxt_bit = bit_ff + 4'h1;
                    nxt_txb = {txb_ff[6:0], 1'b1};
                end else if (st_ff == M_RDAT) begin
                    nxt_rd = rxb_ff;
                    nxt_rdv = 1'b1;
                    nxt_cnt = cnt_ff - 4'h1;
                    // last byte went out unacknowledged
                    nxt_st = (cnt_ff == 4'h1) ? M_STOP : M_RDAT; // R17
                end else if (samp_ff) begin
                    // no ack: device busy or absent, user polls again
                    nxt_nack = 1'b1;
                    nxt_st = M_STOP; // R09
                end else begin
                    case (st_ff)
                        M_DEVW: begin
                            nxt_st = M_ADDR;
                            nxt_txb = {1'b0, addr_ff}; // R01
                        end
                        M_ADDR: begin
                            // read: the write so far was only a dummy
                            nxt_st = wr_ff ? M_WDAT : M_RSTART; // R16
                            nxt_txb = wr_data;
                            nxt_take = wr_ff;
                        end
                        M_WDAT: begin
                            nxt_cnt = cnt_ff - 4'h1;
                            nxt_st = (cnt_ff == 4'h1) ? M_STOP : M_WDAT; // R02 R07
                            nxt_txb = wr_data;
                            nxt_take = (cnt_ff != 4'h1);
                        end
                        M_DEVR: nxt_st = M_RDAT;
                        default: nxt_st = M_STOP;
                    endcase
                end
            end
        end
        nxt_scl = scl_of(nxt_st, nxt_ph);
        nxt_drv = drv_of(nxt_st, nxt_ph, nxt_bit, nxt_txb, nxt_cnt);
    end

    // sequencer registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_ff <= M_IDLE;
            q_ff <= '0;
            ph_ff <= 2'h0;
            bit_ff <= 4'h0;
            txb_ff <= 8'hff;
            rxb_ff <= 8'h00;
            cnt_ff <= 4'h0;
            wr_ff <= 1'b0;
            addr_ff <= 7'h00;
            samp_ff <= 1'b1;
            drv_ff <= 1'b0;
            scl_ff <= 1'b1;
            nack_ff <= 1'b0;
            rd_ff <= 8'h00;
            rdv_ff <= 1'b0;
            take_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            q_ff <= nxt_q;
            ph_ff <= nxt_ph;
            bit_ff <= nxt_bit;
            txb_ff <= nxt_txb;
            rxb_ff <= nxt_rxb;
            cnt_ff <= nxt_cnt;
            wr_ff <= nxt_wr;
            addr_ff <= nxt_addr;
            samp_ff <= nxt_samp;
            drv_ff <= nxt_drv;
            scl_ff <= nxt_scl;
            nack_ff <= nxt_nack;
            rd_ff <= nxt_rd;
            rdv_ff <= nxt_rdv;
            take_ff <= nxt_take;
            done_ff <= nxt_done;
        end
    end

    // outputs
    assign link.scl = scl_ff;
    assign link.aux_clock_pin = aux_ff;
    assign link.host_sda_o = 1'b0;
    assign link.host_sda_oe_n = ~drv_ff;
    assign cmd_ready = (st_ff == M_IDLE);
    assign wr_take = take_ff;
    assign rd_data = rd_ff;
    assign rd_valid = rdv_ff;
    assign done = done_ff;
    assign nack = nack_ff;
endmodule
`default_nettype wire

// ### tb/eeprom_link_chk.sv
// assertion checker watching the two-wire link between the master and eeprom ends
`timescale 1ns/10ps
`default_nettype none
module eeprom_link_chk #(
    parameter int WR_CYCLES = 200
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // link signals
    input wire logic scl,
    input wire logic aux_clock_pin,
    input wire logic host_sda_o,
    input wire logic host_sda_oe_n,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe_n,
    input wire logic sda,
    // device status
    input wire logic write_busy
);
    int busy_cnt_ff;
    int nxt_busy_cnt;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    // length of the running busy stretch, too long to unroll in a repetition
    always_comb begin
        nxt_busy_cnt = write_busy ? busy_cnt_ff + 1 : 0;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            busy_cnt_ff <= 0;
        end else begin
            busy_cnt_ff <= nxt_busy_cnt;
        end
    end

    // open-drain ends only ever pull low
    chk_dev_pulls_low: assert property (!dev_sda_oe_n |-> !dev_sda_o)
        else $error("device drives data high");
    chk_host_pulls_low: assert property (!host_sda_oe_n |-> !host_sda_o)
        else $error("master drives data high");
    chk_busy_silent: assert property (write_busy |-> dev_sda_oe_n)
        else $error("device drives data while programming");
    chk_dev_change_low: assert property (!$stable(dev_sda_oe_n) |-> !scl && !$past(scl))
        else $error("device data changed outside clock low time");
    chk_ack_hold: assert property ($fell(dev_sda_oe_n) |-> !scl ##1 (!dev_sda_oe_n) [*8])
        else $error("device pull too short or started with clock high");
    chk_busy_on_stop: assert property ($rose(write_busy) |-> scl && sda)
        else $error("programming started without a stop");
    chk_busy_needs_aux: assert property ($rose(write_busy) |-> aux_clock_pin)
        else $error("programming started with write enable low");
    chk_busy_length: assert property ($fell(write_busy) |-> busy_cnt_ff == WR_CYCLES)
        else $error("programming time wrong");
    chk_start_free: assert property (scl && $fell(sda) |-> dev_sda_oe_n)
        else $error("device pulled data during a start");

    // main scenarios
    cov_write_cycle: cover property ($fell(write_busy));
    cov_dev_ack: cover property ($fell(dev_sda_oe_n));
    cov_poll_busy: cover property (write_busy && scl && $fell(sda));
endmodule
`default_nettype wire

// ### tb/two_wire_eeprom_rw_engine_tb.sv
// self-checking bench joining the master and eeprom ends over the two-wire link
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin err_total++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module two_wire_eeprom_rw_engine_tb import eeprom_link_pkg::*;;
    // long enough that a command right after a write still meets a busy device,
    // short enough that the command after that finds it idle, with margin both ways
    localparam int WR_CYC = 11500;
    typedef struct packed {
        logic wr;
        logic [6:0] addr;
        logic [3:0] cnt;
        logic [7:0] d0;
        logic [7:0] d1;
        logic exp_nack;
        logic [7:0] r0;
        logic [7:0] r1;
        logic aux;
    } row_t;
    row_t rows [4];
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic supply_low = 1'b0;
    logic aux_level = 1'b1;
    logic cmd_valid = 1'b0;
    logic cmd_write = 1'b0;
    logic [6:0] cmd_addr = 7'h00;
    logic [3:0] cmd_count = 4'h1;
    logic [7:0] wr_data = 8'h00;
    logic cmd_ready;
    logic wr_take;
    logic [7:0] rd_data;
    logic rd_valid;
    logic done;
    logic nack;
    logic write_busy;
    logic [7:0] got_rd [4];
    int err_total = 0;
    int checked = 0;
    int n_rd = 0;

    eeprom_link_if link ();

    eeprom_dev #(.WR_CYCLES(WR_CYC)) i_eeprom_dev (.ref_clk(ref_clk), .rst(rst), .link(link),
        .supply_low(supply_low), .write_busy(write_busy));

    eeprom_host i_eeprom_host (.ref_clk(ref_clk), .rst(rst), .link(link),
        .aux_level(aux_level), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_addr(cmd_addr), .cmd_count(cmd_count), .cmd_ready(cmd_ready),
        .wr_data(wr_data), .wr_take(wr_take), .rd_data(rd_data), .rd_valid(rd_valid),
        .done(done), .nack(nack));

    eeprom_link_chk #(.WR_CYCLES(WR_CYC)) i_eeprom_link_chk (.ref_clk(ref_clk), .rst(rst),
        .scl(link.scl), .aux_clock_pin(link.aux_clock_pin), .host_sda_o(link.host_sda_o),
        .host_sda_oe_n(link.host_sda_oe_n), .dev_sda_o(link.dev_sda_o),
        .dev_sda_oe_n(link.dev_sda_oe_n), .sda(link.sda), .write_busy(write_busy));

    // 100 MHz clock
    always #5 ref_clk = ~ref_clk;

    // collect read bytes as their one-cycle pulse shows
    always @(posedge ref_clk) begin
        if (rd_valid === 1'b1) begin
            if (n_rd < 4) got_rd[n_rd] = rd_data;
            n_rd++;
        end
    end

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // one command through the master, then compare its outcome
    task automatic run_row(input row_t r);
        int n;
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_write <= r.wr;
        cmd_addr <= r.addr;
        cmd_count <= r.cnt;
        wr_data <= r.d0;
        aux_level <= r.aux;
        n_rd = 0;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 60000) begin
            @(posedge ref_clk);
            if (wr_take === 1'b1) wr_data <= r.d1;
            n++;
        end
        `CHK(done, 1'b1)
        `CHK(nack, r.exp_nack)
        `CHK(n_rd, (r.wr || r.exp_nack) ? 0 : int'(r.cnt))
        if (!r.wr && !r.exp_nack) begin
            `CHK(got_rd[0], r.r0)
            `CHK(got_rd[1], r.r1)
        end
    endtask

    // watchdog sized from the four transfers plus the reset case
    initial begin
        repeat (160000) @(posedge ref_clk);
        err_total++;
        wrap_up();
    end

    initial begin
        // page write of two bytes at the last slot, second wraps to 0x78
        rows[0] = '{1'b1, 7'h7f, 4'h2, 8'ha5, 8'h3c, 1'b0, 8'h00, 8'h00, 1'b1};
        // poll at once: device still programming, device address byte unanswered
        rows[1] = '{1'b0, 7'h7f, 4'h1, 8'h00, 8'h00, 1'b1, 8'h00, 8'h00, 1'b1};
        // aux pin low: write is acked but never programmed
        rows[2] = '{1'b1, 7'h79, 4'h1, 8'h22, 8'h22, 1'b0, 8'h00, 8'h00, 1'b0};
        // random then sequential read from the wrapped slot; 0x79 still erased
        rows[3] = '{1'b0, 7'h78, 4'h2, 8'h00, 8'h00, 1'b0, 8'h3c, MEM_RESET_VAL, 1'b1};
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        for (int i = 0; i < 4; i++) begin
            run_row(rows[i]);
        end
        // reset in mid-transfer must drop the link back to idle at once
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_write <= 1'b1;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        repeat (5000) @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        `CHK(link.scl, 1'b1)
        `CHK(link.sda, 1'b1)
        `CHK(cmd_ready, 1'b1)
        `CHK(write_busy, 1'b0)
        `CHK(nack, 1'b0)
        wrap_up();
    end
endmodule
`default_nettype wire
